// *** hw/iox_cfg.svh ***
// Constants for the IMU output control block
`ifndef IOX_CFG_SVH
`define IOX_CFG_SVH
`define IOX_CLK_HZ 100000000
`define IOX_FAST_RATE_SPS 2000
`define IOX_ST_INTEGRITY 7
`define IOX_ST_STARTUP 6
`define IOX_ST_OUTSIDE 5
`define IOX_ST_OVERLOAD 4
`define IOX_ST_CHERR 3
`define IOX_ST_Z 2
`define IOX_ST_Y 1
`define IOX_ST_X 0
`define IOX_INIT_DGRAMS 3
`define IOX_STARTUP_SAMPLES 16'h0100
`define IOX_AUX_W 24
`define IOX_GAIN_FRAC 16
`define IOX_GAIN_RESET 32'h0001_0000
`define IOX_ADDR_CTRL 12'h000
`define IOX_ADDR_STATUS 12'h004
`define IOX_ADDR_GAIN 12'h008
`define IOX_ADDR_OFFS 12'h00C
`define IOX_ADDR_FILT 12'h010
`define IOX_ADDR_AUX 12'h014
`define IOX_ADDR_FAULT 12'h018
`define IOX_ADDR_CMD 12'h01C
`define IOX_CTRL_EXT 0
`define IOX_CTRL_SVC 1
`define IOX_CMD_CFG 0
`define IOX_CMD_RESET 1
`endif

// *** hw/iox_pkg.sv ***
// Types shared by the IMU output control files
package iox_pkg;
   typedef enum logic [1:0] {IOX_MODE_INIT, IOX_MODE_NORMAL} iox_mode_t;
   typedef enum logic [1:0] {IOX_DG_NONE, IOX_DG_ID, IOX_DG_MEAS, IOX_DG_CFG} iox_dg_t;
endpackage : iox_pkg

// *** hw/iox_sync_if.sv ***
// Interface carrying a synchronised pin level and its falling-edge event
`timescale 1ns/1ps
interface iox_sync_if;
   logic level;
   logic fall;
   modport src (output level, output fall);
   modport dst (input level, input fall);
endinterface : iox_sync_if

// *** hw/iox_pin_sync.sv ***
// Two-stage synchroniser with falling-edge detector
`timescale 1ns/1ps
module iox_pin_sync
   import iox_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pin
   input wire logic pin_in,
   // Result
   iox_sync_if.src out
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   // Pins rest high so an open input never yields a spurious edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign out.level = s2_q;
   assign out.fall = s3_q & ~s2_q;
endmodule : iox_pin_sync

// *** hw/iox_output_ctrl.sv ***
// IMU output control: status byte, reset, trigger, validity strobe, aux path
// Contract
// - Status bit 7 set on system integrity error, else 0.
// - Status bit 5 set while outside operating conditions.
// - Overload sets bit 4 and flags overloaded channels in bits 0-2.
// - Channel error sets bit 3 and flags error channels in bits 0-2.
// - Bit 2 Z, bit 1 Y, bit 0 X or aux channel.
// - Hardware reset is active low, rests inactive when unconnected.
// - Hardware reset forces initialisation mode from any mode.
// - External trigger mode samples continuously at 2000 samples per second.
// - Each trigger falling edge yields exactly one datagram of latest sample; code merges edges seen while busy, drops them before normal mode.
// - Trigger input rests high, never giving a spurious edge.
// - Configuration request produces a datagram regardless of trigger.
// - Three identification datagrams sent during initialisation, even with trigger.
// - Validity strobe rises synchronous with the sample rate.
// - Validity strobe falls after the datagram's last bit is sent.
// - In trigger mode the strobe does not mark transmission.
// - Without trigger mode, measure and transmit automatically after power-on.
// - Aux value is 24 bits followed by a status byte.
// - Aux sample compensated as gain times input plus offset.
// - Aux data low-pass filtered with configurable bandwidth.
// - Status bit 6 held during gyro start-up after init, then cleared.
// - After three init datagrams, move to normal mode automatically.
// - Transmission continues whatever errors the status byte reports.
`timescale 1ns/1ps
`include "iox_cfg.svh"
module iox_output_ctrl
   import iox_pkg::*;
#(
   parameter int SAMPLE_RATE = `IOX_FAST_RATE_SPS,
   parameter int CLK_HZ = `IOX_CLK_HZ,
   parameter int STARTUP_SAMPLES = `IOX_STARTUP_SAMPLES
)
(
   // AHB-Lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device pins
   input wire logic hw_reset_low_in,
   input wire logic sample_request_in,
   output logic validity_strobe,
   // Sensor health inputs
   input wire logic integrity_err,
   input wire logic outside_cond,
   input wire logic [2:0] overload_ch,
   input wire logic [2:0] chan_err,
   // Aux converter sample
   input wire logic aux_valid,
   input wire logic [`IOX_AUX_W-1:0] aux_raw,
   // Serial transmitter handshake
   output logic tx_start,
   output logic [1:0] tx_kind,
   output logic [7:0] tx_status,
   output logic [`IOX_AUX_W-1:0] tx_aux,
   input wire logic tx_done
);
   localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_RATE;
   localparam int DW = $clog2(SAMPLE_DIV + 1);
   // Refuse settings that the tick divider or the start-up counter cannot serve
   if (SAMPLE_RATE < 1 || SAMPLE_RATE > CLK_HZ)
   begin : g_bad_rate
      $error("iox_output_ctrl: sample rate out of range");
   end
   if (SAMPLE_DIV < 2)
   begin : g_bad_div
      $error("iox_output_ctrl: sample divider below two");
   end
   if (STARTUP_SAMPLES < 1 || STARTUP_SAMPLES > 16'hFFFF)
   begin : g_bad_startup
      $error("iox_output_ctrl: start-up count does not fit sixteen bits");
   end
   // Synchronised pins
   iox_sync_if trig_s ();
   iox_sync_if rst_s ();
   iox_pin_sync u_trig (.hclk(hclk), .hresetn(hresetn), .pin_in(sample_request_in), .out(trig_s));
   iox_pin_sync u_rst (.hclk(hclk), .hresetn(hresetn), .pin_in(hw_reset_low_in), .out(rst_s));
   // The pin acts two clocks late, once both synchroniser stages have seen it
   // Active low pin; the synchroniser resets high, modelling the pull-up
   wire hw_rst = ~rst_s.level;
   // AHB-Lite slave
   logic ap_wr_q;
   logic ap_rd_q;
   logic [11:0] ap_addr_q;
   wire ap_valid = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_wr_q <= 1'b0;
         ap_rd_q <= 1'b0;
         ap_addr_q <= 12'h000;
      end
      else if (hready)
      begin
         ap_wr_q <= ap_valid & hwrite;
         ap_rd_q <= ap_valid & ~hwrite;
         ap_addr_q <= haddr[11:0];
      end
   end
   // A pin reset keeps the configuration; only the controller returns to init
   logic [31:0] ctrl_q;
   logic [31:0] gain_q;
   logic [31:0] offs_q;
   logic [3:0] filt_q;
   wire wr_ctrl = ap_wr_q & (ap_addr_q == `IOX_ADDR_CTRL);
   wire wr_gain = ap_wr_q & (ap_addr_q == `IOX_ADDR_GAIN);
   wire wr_offs = ap_wr_q & (ap_addr_q == `IOX_ADDR_OFFS);
   wire wr_filt = ap_wr_q & (ap_addr_q == `IOX_ADDR_FILT);
   wire wr_cmd = ap_wr_q & (ap_addr_q == `IOX_ADDR_CMD);
   wire ext_mode = ctrl_q[`IOX_CTRL_EXT];
   wire svc_mode = ctrl_q[`IOX_CTRL_SVC];
   wire cmd_cfg = wr_cmd & hwdata[`IOX_CMD_CFG];
   wire cmd_rst = wr_cmd & hwdata[`IOX_CMD_RESET];
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= 32'h0000_0000;
         gain_q <= `IOX_GAIN_RESET;
         offs_q <= 32'h0000_0000;
         filt_q <= 4'h0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= {30'h0, hwdata[1:0]};
         // Coefficients and bandwidth change only in service mode
         if (wr_gain && svc_mode)
            gain_q <= hwdata;
         if (wr_offs && svc_mode)
            offs_q <= hwdata;
         if (wr_filt && svc_mode)
            filt_q <= hwdata[3:0];
      end
   end
   // Operating mode and init sequence
   iox_mode_t mode_q;
   logic [1:0] id_cnt_q;
   logic [15:0] stab_q;
   logic busy_q;
   logic pend_cfg_q;
   logic pend_meas_q;
   wire enter_init = hw_rst | cmd_rst;
   // Sample tick from the internal divider, fixed fast rate
   logic [DW-1:0] div_q;
   wire tick = (div_q == DW'(SAMPLE_DIV - 1));
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_q <= '0;
      else
         div_q <= tick ? '0 : div_q + 1'b1;
   end
   // Aux: compensate then first-order low-pass, shift set by bandwidth
   logic signed [`IOX_AUX_W-1:0] aux_filt_q;
   // Gain is Q16.16, so its fraction bits are dropped after the product
   wire signed [31:0] aux_wide = 32'($signed(aux_raw));
   wire signed [63:0] aux_prod = $signed(gain_q) * aux_wide;
   wire signed [31:0] aux_comp = 32'(aux_prod >>> `IOX_GAIN_FRAC) + $signed(offs_q);
   wire signed [31:0] aux_diff = aux_comp - 32'(aux_filt_q);
   wire signed [31:0] aux_step = aux_diff >>> filt_q;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         aux_filt_q <= '0;
      else if (aux_valid)
         aux_filt_q <= aux_filt_q + aux_step[`IOX_AUX_W-1:0];
   end
   // Datagram dispatch
   wire can_send = ~busy_q & ~enter_init;
   wire send_id = can_send & (mode_q == IOX_MODE_INIT);
   wire send_cfg = can_send & (mode_q == IOX_MODE_NORMAL) & pend_cfg_q;
   wire send_meas = can_send & (mode_q == IOX_MODE_NORMAL) & ~pend_cfg_q & pend_meas_q;
   wire meas_req = ext_mode ? trig_s.fall : tick;
   wire last_id = send_id & (id_cnt_q == 2'(`IOX_INIT_DGRAMS - 1));
   wire any_send = send_id | send_cfg | send_meas;
   // Mode and init datagram count
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_q <= IOX_MODE_INIT;
         id_cnt_q <= 2'h0;
      end
      else if (enter_init)
      begin
         mode_q <= IOX_MODE_INIT;
         id_cnt_q <= 2'h0;
      end
      else if (send_id)
      begin
         id_cnt_q <= id_cnt_q + 2'h1;
         if (last_id)
            mode_q <= IOX_MODE_NORMAL;
      end
   end
   // Transmitter busy from dispatch until the last bit has left
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         busy_q <= 1'b0;
      else if (enter_init)
         busy_q <= 1'b0;
      else if (any_send)
         busy_q <= 1'b1;
      else if (tx_done)
         busy_q <= 1'b0;
   end
   // Start-up count runs in sample ticks once normal mode is entered
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stab_q <= 16'h0000;
      else if (enter_init)
         stab_q <= 16'h0000;
      else if (last_id)
         stab_q <= 16'(STARTUP_SAMPLES);
      else if (tick && stab_q != 16'h0000 && mode_q == IOX_MODE_NORMAL)
         stab_q <= stab_q - 16'h0001;
   end
   // New requests win over the clear from dispatch
   // Requests that arrive while busy coalesce into one datagram
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_cfg_q <= 1'b0;
         pend_meas_q <= 1'b0;
      end
      else if (enter_init)
      begin
         pend_cfg_q <= 1'b0;
         pend_meas_q <= 1'b0;
      end
      else
      begin
         if (cmd_cfg)
            pend_cfg_q <= 1'b1;
         else if (send_cfg)
            pend_cfg_q <= 1'b0;
         // Sample requests before normal mode are dropped, not queued
         if (meas_req && mode_q == IOX_MODE_NORMAL)
            pend_meas_q <= 1'b1;
         else if (send_meas)
            pend_meas_q <= 1'b0;
      end
   end
   // Status byte, built from present health regardless of faults
   logic [7:0] status_b;
   wire [2:0] ch_flags = (overload_ch | chan_err);
   always_comb
   begin
      status_b = 8'h00;
      status_b[`IOX_ST_INTEGRITY] = integrity_err;
      status_b[`IOX_ST_STARTUP] = (stab_q != 16'h0000);
      status_b[`IOX_ST_OUTSIDE] = outside_cond;
      status_b[`IOX_ST_OVERLOAD] = |overload_ch;
      status_b[`IOX_ST_CHERR] = |chan_err;
      status_b[`IOX_ST_Z] = ch_flags[2];
      status_b[`IOX_ST_Y] = ch_flags[1];
      status_b[`IOX_ST_X] = ch_flags[0];
   end
   // Transmit outputs
   logic [1:0] kind_d;
   assign kind_d = send_id ? 2'(IOX_DG_ID) : (send_cfg ? 2'(IOX_DG_CFG) : 2'(IOX_DG_MEAS));
   logic [31:0] rdata_d;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_start <= 1'b0;
         tx_kind <= 2'(IOX_DG_NONE);
         tx_status <= 8'h00;
         tx_aux <= '0;
      end
      else
      begin
         tx_start <= any_send;
         if (any_send)
         begin
            tx_kind <= kind_d;
            tx_status <= status_b;
            tx_aux <= aux_filt_q;
         end
      end
   end
   // Validity strobe; in trigger mode it only marks the sample ticks
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         validity_strobe <= 1'b0;
      else if (enter_init)
         validity_strobe <= 1'b0;
      else if (ext_mode)
         validity_strobe <= tick;
      else if (tick && mode_q == IOX_MODE_NORMAL)
         validity_strobe <= 1'b1;
      else if (tx_done)
         validity_strobe <= 1'b0;
   end
   // Read mux
   always_comb
   begin
      unique case (ap_addr_q)
         `IOX_ADDR_CTRL: rdata_d = ctrl_q;
         `IOX_ADDR_STATUS: rdata_d = {22'h0, mode_q == IOX_MODE_NORMAL, busy_q, status_b};
         `IOX_ADDR_GAIN: rdata_d = gain_q;
         `IOX_ADDR_OFFS: rdata_d = offs_q;
         `IOX_ADDR_FILT: rdata_d = {28'h0, filt_q};
         `IOX_ADDR_AUX: rdata_d = {8'h00, aux_filt_q};
         `IOX_ADDR_FAULT: rdata_d = {24'h0, status_b};
         default: rdata_d = 32'h0000_0000;
      endcase
   end
   // Each read gets one wait state: the registered read data then stands in the
   // data phase, and a write in the data phase just before it has already landed
   wire rd_take = ap_valid & ~hwrite;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         if (ap_rd_q && !hreadyout)
            hrdata <= rdata_d;
         hreadyout <= ~rd_take;
         hresp <= 1'b0;
      end
   end
endmodule : iox_output_ctrl

// *** tb/iox_properties.sv ***
// Checker watching the IMU output control ports
`timescale 1ns/1ps
module iox_properties (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hw_reset_low_in,
   // Bus response and strobe
   input wire logic hresp,
   input wire logic validity_strobe,
   // Health inputs
   input wire logic integrity_err,
   input wire logic outside_cond,
   input wire logic [2:0] overload_ch,
   input wire logic [2:0] chan_err,
   // Transmitter handshake
   input wire logic tx_start,
   input wire logic [1:0] tx_kind,
   input wire logic [7:0] tx_status,
   input wire logic tx_done
);
   logic busy_q;
   wire meas = tx_start && tx_kind == 2'h2;
   // A pin reset drops any datagram in flight, so it also frees the line
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         busy_q <= 1'b0;
      else
         busy_q <= tx_start | (busy_q & ~tx_done & hw_reset_low_in);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   a_start_pulse: assert property (tx_start |=> !tx_start)
      else $error("tx_start longer than one cycle");
   a_status_integrity: assert property (
      meas && $stable(integrity_err) |-> tx_status[7] == integrity_err)
      else $error("integrity bit wrong");
   a_status_outside: assert property (
      meas && $stable(outside_cond) |-> tx_status[5] == outside_cond)
      else $error("outside bit wrong");
   a_status_overload: assert property (
      meas && $stable(overload_ch) |-> tx_status[4] == (|overload_ch))
      else $error("overload bit wrong");
   a_status_cherr: assert property (
      meas && $stable(chan_err) |-> tx_status[3] == (|chan_err))
      else $error("channel error bit wrong");
   a_channel_flags: assert property (
      meas && $stable(overload_ch) && $stable(chan_err)
      |-> tx_status[2:0] == (overload_ch | chan_err))
      else $error("channel flags wrong");
   a_one_datagram: assert property (tx_start |-> !busy_q)
      else $error("datagram started while busy");
   a_strobe_fall: assert property (
      $fell(validity_strobe) && $past(validity_strobe, 2) && hw_reset_low_in
      && $past(hw_reset_low_in, 3) |-> $past(tx_done))
      else $error("strobe fell before last bit");
endmodule : iox_properties

bind iox_output_ctrl iox_properties iox_properties_i (.hclk(hclk), .hresetn(hresetn),
   .hw_reset_low_in(hw_reset_low_in), .hresp(hresp), .validity_strobe(validity_strobe),
   .integrity_err(integrity_err), .outside_cond(outside_cond), .overload_ch(overload_ch),
   .chan_err(chan_err), .tx_start(tx_start), .tx_kind(tx_kind), .tx_status(tx_status),
   .tx_done(tx_done));

// *** tb/iox_host_model.sv ***
// Serial transmitter stand-in that finishes each datagram after a delay
`timescale 1ns/1ps
module iox_host_model #(
   parameter int DELAY = 20
)
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Datagram handshake
   input wire logic tx_start,
   input wire logic [7:0] tx_status,
   output logic tx_done
);
   int cnt_q;
   logic [7:0] seen_q;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         cnt_q <= 0;
         tx_done <= 1'b0;
         seen_q <= 8'h00;
      end
      else
      begin
         tx_done <= (cnt_q == 1);
         if (tx_start)
         begin
            cnt_q <= DELAY;
            seen_q <= tx_status; // Status kept from the latest datagram only
         end
         else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
      end
endmodule : iox_host_model

// *** tb/imu_output_control_bench.sv ***
// Self-checking bench for the IMU output control block
`timescale 1ns/1ps
module imu_output_control_bench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, aux_valid = 1'b0;
   logic hw_reset_low_in = 1'b1, sample_request_in = 1'b1;
   logic integrity_err = 1'b0, outside_cond = 1'b0, strobe_q = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
   logic [1:0] htrans = 2'h0, tx_kind;
   logic [2:0] hsize = 3'h2, overload_ch = 3'h0, chan_err = 3'h0;
   logic [23:0] aux_raw = 24'h0, tx_aux;
   logic [7:0] tx_status;
   logic hreadyout, hresp, validity_strobe, tx_start, tx_done;
   int failures = 0, checks = 0, rises = 0;
   logic [1:0] q_kind[$];
   logic [7:0] q_st[$];
   logic [23:0] q_aux[$];
   always #5 hclk = ~hclk;
   // Tick shortened to 100 cycles to keep the run brief
   iox_output_ctrl #(.SAMPLE_RATE(1000000), .STARTUP_SAMPLES(4)) iox_output_ctrl_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .hw_reset_low_in(hw_reset_low_in), .sample_request_in(sample_request_in),
      .validity_strobe(validity_strobe), .integrity_err(integrity_err),
      .outside_cond(outside_cond), .overload_ch(overload_ch), .chan_err(chan_err),
      .aux_valid(aux_valid), .aux_raw(aux_raw), .tx_start(tx_start), .tx_kind(tx_kind),
      .tx_status(tx_status), .tx_aux(tx_aux), .tx_done(tx_done));
   iox_host_model iox_host_model_i (.hclk(hclk), .hresetn(hresetn), .tx_start(tx_start),
      .tx_status(tx_status), .tx_done(tx_done));
   always @(posedge hclk)
   begin
      strobe_q <= validity_strobe;
      if (validity_strobe === 1'b1 && strobe_q === 1'b0)
         rises++;
      if (tx_start === 1'b1)
      begin
         q_kind.push_back(tx_kind);
         q_st.push_back(tx_status);
         q_aux.push_back(tx_aux);
      end
   end
   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask : ahb
   task wait_dg(input int n);
      for (int i = 0; i < 3000 && q_kind.size() < n; i++)
         @(posedge hclk);
   endtask : wait_dg
   task clear_q;
      q_kind.delete();
      q_st.delete();
      q_aux.delete();
   endtask : clear_q
   task t_init;
      wait_dg(4);
      for (int i = 0; i < 3; i++)
         check(q_kind[i], 2'h1, "init kind");
      check(q_kind[3], 2'h2, "auto meas");
      check(q_st[3][6], 1'b1, "startup flag");
   endtask : t_init
   task stat(input logic i, input logic o, input logic [2:0] ov, input logic [2:0] ce,
      input logic [7:0] exp);
      @(posedge hclk);
      integrity_err <= i;
      outside_cond <= o;
      overload_ch <= ov;
      chan_err <= ce;
      clear_q();
      wait_dg(2);
      check(q_st[1], exp, "status byte");
   endtask : stat
   task t_status;
      repeat (600) @(posedge hclk);
      stat(1'b1, 1'b0, 3'h0, 3'h0, 8'h80);
      stat(1'b0, 1'b1, 3'h0, 3'h0, 8'h20);
      stat(1'b0, 1'b0, 3'h2, 3'h0, 8'h12);
      stat(1'b0, 1'b0, 3'h0, 3'h5, 8'h0D);
      stat(1'b1, 1'b1, 3'h4, 3'h1, 8'hBD);
      stat(1'b0, 1'b0, 3'h0, 3'h0, 8'h00);
   endtask : t_status
   task aux_in(input logic [23:0] x);
      @(posedge hclk);
      aux_raw <= x;
      aux_valid <= 1'b1;
      @(posedge hclk);
      aux_valid <= 1'b0;
      repeat (4) @(posedge hclk);
      ahb(1'b0, 32'h14, 32'h0);
   endtask : aux_in
   task t_aux;
      ahb(1'b0, 32'h8, 32'h0);
      check(rdv, 32'h10000, "gain reset");
      ahb(1'b1, 32'h0, 32'h2);
      ahb(1'b1, 32'h8, 32'h20000);
      ahb(1'b1, 32'hC, 32'h5);
      ahb(1'b1, 32'h10, 32'h0);
      ahb(1'b1, 32'h0, 32'h0);
      aux_in(24'h100);
      check(rdv, 32'h205, "aux comp");
      clear_q();
      wait_dg(2);
      check(q_aux[1], 24'h205, "aux field");
      ahb(1'b1, 32'h0, 32'h2);
      ahb(1'b1, 32'h10, 32'h1);
      ahb(1'b1, 32'h0, 32'h0);
      aux_in(24'h0);
      check(rdv, 32'h105, "aux filter");
      ahb(1'b0, 32'h40, 32'h0);
      check(rdv, 32'h0, "unmapped");
   endtask : t_aux
   task t_trig;
      // Switch only while idle so an open strobe is not cut short
      wait (validity_strobe === 1'b1);
      @(posedge hclk iff validity_strobe === 1'b0);
      ahb(1'b1, 32'h0, 32'h1);
      repeat (200) @(posedge hclk);
      clear_q();
      rises = 0;
      repeat (1000) @(posedge hclk);
      check(q_kind.size(), 0, "idle trigger");
      check(rises >= 9 && rises <= 11, 1'b1, "strobe rate");
      sample_request_in <= 1'b0;
      repeat (5) @(posedge hclk);
      sample_request_in <= 1'b1;
      repeat (300) @(posedge hclk);
      check(q_kind.size(), 1, "one per edge");
      check(q_kind[0], 2'h2, "trigger kind");
      ahb(1'b1, 32'h1C, 32'h1);
      repeat (300) @(posedge hclk);
      check(q_kind.size(), 2, "cfg count");
      check(q_kind[1], 2'h3, "cfg kind");
   endtask : t_trig
   task t_pin;
      clear_q();
      @(posedge hclk);
      hw_reset_low_in <= 1'b0;
      repeat (5) @(posedge hclk);
      hw_reset_low_in <= 1'b1;
      wait_dg(3);
      for (int i = 0; i < 3; i++)
         check(q_kind[i], 2'h1, "pin reset init");
   endtask : t_pin
   task close_out;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_init();
      t_status();
      t_aux();
      t_trig();
      t_pin();
      close_out();
   end
   initial
   begin
      #500000;
      failures++;
      close_out();
   end
endmodule : imu_output_control_bench
